// ---- burst_sram_pkg.sv ----
// Shared constants and carrier types for the pipelined burst SRAM port
package burst_sram_pkg;

	localparam int LANE_COUNT = 4;
	localparam int LANE_DATA_W = 8;
	localparam int DATA_W = LANE_COUNT * LANE_DATA_W;
	localparam int ADDR_W = 6;
	localparam int WORD_W = DATA_W + LANE_COUNT;

	localparam int BURST_BEATS = 4;
	localparam int BEAT_W = 2;

	// Sleep entry and exit each take two clock cycles
	localparam int SLEEP_ENTRY_CYC = 2;
	localparam int SLEEP_EXIT_CYC = 2;
	localparam int SLEEP_CNT_W = 2;
	localparam logic [SLEEP_CNT_W-1:0] SLEEP_CNT_RESET = 2'h0;

	localparam int SYNC_STAGES = 3;

	localparam logic [LANE_COUNT-1:0] MASK_NONE = 4'hF;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h00;
	localparam logic [BEAT_W-1:0] BEAT_RESET = 2'h0;
	localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
	localparam logic [LANE_COUNT-1:0] PARITY_RESET = 4'h0;

	typedef enum logic [1:0] {
		SLEEP_AWAKE,
		SLEEP_ENTERING,
		SLEEP_ASLEEP,
		SLEEP_LEAVING
	} sleep_state_t;

	// One access as it moves down the pipeline
	typedef struct packed {
		logic                  valid;
		logic                  write;
		logic [ADDR_W-1:0]     addr;
		logic [LANE_COUNT-1:0] mask_n;
	} access_t;

	localparam access_t ACCESS_IDLE = '{
		valid: 1'b0,
		write: 1'b0,
		addr: ADDR_RESET,
		mask_n: MASK_NONE
	};

	// Data word and its per-lane parity bits
	typedef struct packed {
		logic [DATA_W-1:0]     data;
		logic [LANE_COUNT-1:0] parity;
	} word_t;

endpackage

// ---- pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module pin_sync
	import burst_sram_pkg::*;
#(
	parameter int          WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// Asynchronous pin and filtered level
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level
);

	logic [WIDTH-1:0] stage [SYNC_STAGES];

	// First stage feeds only the second stage
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				stage[i] <= RESET_LEVEL;
			end
		end else begin
			stage[0] <= pin_in;
			for (int i = 1; i < SYNC_STAGES; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	// A bit changes only once the last two stages agree
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			level <= RESET_LEVEL;
		end else begin
			for (int b = 0; b < WIDTH; b++) begin
				if (stage[1][b] == stage[2][b]) begin
					level[b] <= stage[2][b];
				end
			end
		end
	end

endmodule

`default_nettype wire

// ---- burst_sram_port.sv ----
// Pipelined zero-turnaround burst SRAM port with byte writes and sleep
`timescale 1ns/10ps
`default_nettype none

module burst_sram_port
	import burst_sram_pkg::*;
#(
	parameter int DEPTH = 1 << ADDR_W
) (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	// Command pins, synchronous to core_clk
	input  wire logic [ADDR_W-1:0]     addr,
	input  wire logic                  chip_select_1_n,
	input  wire logic                  chip_select_2,
	input  wire logic                  chip_select_3_n,
	input  wire logic                  write_strobe_n,
	input  wire logic [LANE_COUNT-1:0] byte_lane_mask_n,
	input  wire logic                  step_or_fetch_n,
	input  wire logic                  clk_qualify_n,
	// Asynchronous controls
	input  wire logic                  out_drive_en_n,
	input  wire logic                  sleep_request,
	input  wire logic                  burst_order,
	// Data pins split into in, out and enable
	input  wire logic [DATA_W-1:0]     data_io_in,
	output logic      [DATA_W-1:0]     data_io_out,
	output logic      [DATA_W-1:0]     data_io_oe_n,
	input  wire logic [LANE_COUNT-1:0] parity_io_in,
	output logic      [LANE_COUNT-1:0] parity_io_out,
	output logic      [LANE_COUNT-1:0] parity_io_oe_n
);

	// Burst address low bits for a given beat
	function automatic logic [BEAT_W-1:0] burst_low(
		input logic [BEAT_W-1:0] start,
		input logic [BEAT_W-1:0] beat,
		input logic              interleaved
	);
		logic [BEAT_W-1:0] result;
		result = interleaved ? (start ^ beat) : BEAT_W'(start + beat);
		return result;
	endfunction

	// Merge a lane-masked write into an existing word
	function automatic word_t lane_merge(
		input word_t                 old_word,
		input word_t                 new_word,
		input logic [LANE_COUNT-1:0] mask_n
	);
		word_t result;
		result = old_word;
		for (int l = 0; l < LANE_COUNT; l++) begin
			if (!mask_n[l]) begin
				result.data[l*LANE_DATA_W +: LANE_DATA_W] = new_word.data[l*LANE_DATA_W +: LANE_DATA_W];
				result.parity[l] = new_word.parity[l];
			end
		end
		return result;
	endfunction

	word_t        mem [DEPTH];
	logic         sleep_level;
	logic         order_level;
	sleep_state_t sleep_state;
	logic [SLEEP_CNT_W-1:0] sleep_cnt;
	logic         awake;
	logic         edge_taken;
	logic         selected;
	logic         burst_live;
	logic         burst_write;
	logic [ADDR_W-1:0] burst_base;
	logic [BEAT_W-1:0] burst_beat;
	logic [BEAT_W-1:0] next_beat;
	access_t      next_cmd;
	access_t      cmd_stage;
	access_t      data_stage;
	word_t        pin_word;
	word_t        read_word;
	word_t        out_word;
	logic         read_drive;
	logic         drive_n;

	// Sleep pin and burst order strap cross in through three synchroniser flops and a filter flop
	pin_sync #(
		.WIDTH       (2),
		.RESET_LEVEL (2'h1)
	) u_pin_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_in   ({sleep_request, burst_order}),
		.level    ({sleep_level, order_level})
	);

	assign awake = (sleep_state == SLEEP_AWAKE);
	// While awake, a high clk_qualify_n freezes every register below except the sleep sequencer
	assign edge_taken = awake && !clk_qualify_n;
	assign selected = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
	assign next_beat = BEAT_W'(burst_beat + 1'b1);
	assign pin_word = {data_io_in, parity_io_in};

	// Sleep sequencer: two cycles of agreement to enter or leave
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sleep_state <= SLEEP_AWAKE;
			sleep_cnt <= SLEEP_CNT_RESET;
		end else begin
			case (sleep_state)
				SLEEP_AWAKE: begin
					sleep_cnt <= SLEEP_CNT_RESET;
					if (sleep_level) begin
						sleep_state <= SLEEP_ENTERING;
						sleep_cnt <= SLEEP_CNT_W'(1);
					end
				end
				SLEEP_ENTERING: begin
					if (!sleep_level) begin
						sleep_state <= SLEEP_AWAKE;
					end else if (sleep_cnt >= SLEEP_CNT_W'(SLEEP_ENTRY_CYC - 1)) begin
						sleep_state <= SLEEP_ASLEEP;
						sleep_cnt <= SLEEP_CNT_RESET;
					end else begin
						sleep_cnt <= SLEEP_CNT_W'(sleep_cnt + 1'b1);
					end
				end
				SLEEP_ASLEEP: begin
					if (!sleep_level) begin
						sleep_state <= SLEEP_LEAVING;
						sleep_cnt <= SLEEP_CNT_W'(1);
					end
				end
				SLEEP_LEAVING: begin
					if (sleep_level) begin
						sleep_state <= SLEEP_ASLEEP;
					end else if (sleep_cnt >= SLEEP_CNT_W'(SLEEP_EXIT_CYC - 1)) begin
						sleep_state <= SLEEP_AWAKE;
						sleep_cnt <= SLEEP_CNT_RESET;
					end else begin
						sleep_cnt <= SLEEP_CNT_W'(sleep_cnt + 1'b1);
					end
				end
				default: begin
					sleep_state <= SLEEP_AWAKE;
					sleep_cnt <= SLEEP_CNT_RESET;
				end
			endcase
		end
	end

	// Decode of the command presented at this edge
	always_comb begin
		next_cmd = ACCESS_IDLE;
		if (!step_or_fetch_n) begin
			if (selected) begin
				next_cmd.valid = 1'b1;
				next_cmd.write = !write_strobe_n;
				next_cmd.addr = addr;
				next_cmd.mask_n = byte_lane_mask_n;
			end
		end else if (burst_live) begin
			// Selects and strobe are ignored on a step
			next_cmd.valid = 1'b1;
			next_cmd.write = burst_write;
			next_cmd.addr = {burst_base[ADDR_W-1:BEAT_W], burst_low(burst_base[BEAT_W-1:0], next_beat, order_level)};
			next_cmd.mask_n = byte_lane_mask_n;
		end
	end

	// Burst tracking: base address, beat and latched access type
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			burst_live <= 1'b0;
			burst_write <= 1'b0;
			burst_base <= ADDR_RESET;
			burst_beat <= BEAT_RESET;
		end else if (!awake) begin
			burst_live <= 1'b0;
		end else if (edge_taken) begin
			if (!step_or_fetch_n) begin
				burst_live <= selected;
				burst_write <= !write_strobe_n;
				burst_base <= addr;
				burst_beat <= BEAT_RESET;
			end else if (burst_live) begin
				// Beat index wraps, so a fourth step revisits the start
				burst_beat <= next_beat;
			end
		end
	end

	// Address and control stage
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cmd_stage <= ACCESS_IDLE;
		end else if (!awake) begin
			cmd_stage <= ACCESS_IDLE;
		end else if (edge_taken) begin
			cmd_stage <= next_cmd;
		end
	end

	// Write data stage: the write waits one more edge for its data
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			data_stage <= ACCESS_IDLE;
		end else if (!awake) begin
			data_stage <= ACCESS_IDLE;
		end else if (edge_taken) begin
			if (cmd_stage.valid && cmd_stage.write) begin
				data_stage <= cmd_stage;
			end else begin
				data_stage <= ACCESS_IDLE;
			end
		end
	end

	// Array write at the second edge after the command
	always_ff @(posedge core_clk) begin
		if (edge_taken && data_stage.valid && data_stage.write) begin
			mem[data_stage.addr] <= lane_merge(mem[data_stage.addr], pin_word, data_stage.mask_n);
		end
	end

	// Forward a write landing this edge so a following read sees it
	always_comb begin
		read_word = mem[cmd_stage.addr];
		if (data_stage.valid && data_stage.write && data_stage.addr == cmd_stage.addr) begin
			read_word = lane_merge(read_word, pin_word, data_stage.mask_n);
		end
	end

	// Output register and read drive flag
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			out_word.data <= DATA_RESET;
			out_word.parity <= PARITY_RESET;
			read_drive <= 1'b0;
		end else if (!awake) begin
			read_drive <= 1'b0;
		end else if (edge_taken) begin
			if (cmd_stage.valid && !cmd_stage.write) begin
				out_word <= read_word;
				read_drive <= 1'b1;
			end else begin
				// Deselect or write: float from this edge on
				read_drive <= 1'b0;
			end
		end
	end

	// Output enable is combined without sampling, so it acts at once
	assign drive_n = !read_drive || out_drive_en_n;
	assign data_io_out = out_word.data;
	assign parity_io_out = out_word.parity;
	assign data_io_oe_n = {DATA_W{drive_n}};
	assign parity_io_oe_n = {LANE_COUNT{drive_n}};

endmodule

`default_nettype wire

// ---- burst_sram_monitor.sv ----
// Port checker for the burst SRAM port
`timescale 1ns/10ps
`default_nettype none

module burst_sram_monitor
	import burst_sram_pkg::*;
(
	// Clock, reset and commands
	input wire logic core_clk, sys_rst, chip_select_1_n, chip_select_2, chip_select_3_n,
	input wire logic write_strobe_n, step_or_fetch_n, clk_qualify_n, out_drive_en_n, sleep_request,
	// Data pins
	input wire logic [DATA_W-1:0]     data_io_out, data_io_oe_n,
	input wire logic [LANE_COUNT-1:0] parity_io_oe_n
);
	logic [3:0] calm;
	logic       sel, ld, fl;
	assign sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
	assign ld = calm == 4'hF && !clk_qualify_n && !step_or_fetch_n;
	assign fl = &data_io_oe_n;
	// Sleep sync lag makes edges near a request unpredictable, so skip them
	always_ff @(posedge core_clk) begin
		if (sys_rst || sleep_request) begin
			calm <= 4'h0;
		end else if (calm != 4'hF) begin
			calm <= calm + 4'h1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	AST_WRITE_FLOAT: assert property (ld && sel && !write_strobe_n ##1 !clk_qualify_n |=> fl)
		else $error("write did not float data");
	AST_DESEL_FLOAT: assert property (ld && !sel ##1 !clk_qualify_n |=> fl)
		else $error("deselect did not float data");
	AST_READ_DRIVE: assert property (ld && sel && write_strobe_n ##1 !clk_qualify_n ##1 !out_drive_en_n
		|-> data_io_oe_n == '0)
		else $error("read data not driven");
	AST_OE_FLOAT: assert property (out_drive_en_n |-> fl && &parity_io_oe_n)
		else $error("drivers on with enable high");
	AST_PARITY_PAIR: assert property (fl == &parity_io_oe_n)
		else $error("parity enable differs from data");
	AST_STALL_HOLD: assert property (calm == 4'hF && clk_qualify_n && !out_drive_en_n ##1 !out_drive_en_n
		|-> $stable(data_io_oe_n) && $stable(data_io_out))
		else $error("stalled edge changed outputs");
	AST_RESET_FLOAT: assert property ($fell(sys_rst) |-> fl && &parity_io_oe_n)
		else $error("not floated after reset");
	AST_SLEEP_FLOAT: assert property (sleep_request [*8] |-> fl)
		else $error("asleep with drivers on");
	cover property (ld && sel && !write_strobe_n);
	cover property (ld && sel && write_strobe_n ##1 step_or_fetch_n && !clk_qualify_n);
	cover property (clk_qualify_n);
	cover property (sleep_request [*8]);
endmodule

bind burst_sram_port burst_sram_monitor mon (.core_clk(core_clk), .sys_rst(sys_rst),
	.chip_select_1_n(chip_select_1_n), .chip_select_2(chip_select_2), .chip_select_3_n(chip_select_3_n),
	.write_strobe_n(write_strobe_n), .step_or_fetch_n(step_or_fetch_n), .clk_qualify_n(clk_qualify_n),
	.out_drive_en_n(out_drive_en_n), .sleep_request(sleep_request), .data_io_out(data_io_out),
	.data_io_oe_n(data_io_oe_n), .parity_io_oe_n(parity_io_oe_n));

`default_nettype wire

// ---- sram_ctrl_model.sv ----
// Controller-side model resolving the shared data and parity wires
`timescale 1ns/10ps
`default_nettype none

module sram_ctrl_model
	import burst_sram_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              drive,
	input wire word_t             wdata,
	input wire word_t             dev_out,
	input wire logic [WORD_W-1:0] dev_oe_n,
	output var word_t             wire_val
);
	word_t last;
	// Undriven wires flip every cycle so a stale value never passes
	always_comb begin
		for (int i = 0; i < WORD_W; i++) begin
			wire_val[i] = drive ? wdata[i] : (!dev_oe_n[i] ? dev_out[i] : ~last[i]);
		end
	end
	always_ff @(posedge core_clk) begin
		last <= wire_val;
	end
endmodule

`default_nettype wire

// ---- test_burst_sram_port.sv ----
// Self-checking bench for the burst SRAM port
`timescale 1ns/10ps
`default_nettype none

module test_burst_sram_port
	import burst_sram_pkg::*;
;
	logic        clk, rst, q, st, we_n, oe, zz, ord, drv, pdn, live, bwr;
	logic [2:0]  cs;
	logic [5:0]  a, base;
	logic [3:0]  m, poe, pout;
	logic [31:0] dout, doe;
	logic [1:0]  k;
	logic [1:0]  pk [2];
	logic [5:0]  pa [2];
	logic [3:0]  pm [2];
	logic [35:0] pd [2];
	logic [35:0] mem [64];
	word_t       wd, w;
	int          err_total, check_count;

	burst_sram_port DUT (.core_clk(clk), .sys_rst(rst), .addr(a), .chip_select_1_n(cs[0]),
		.chip_select_2(cs[1]), .chip_select_3_n(cs[2]), .write_strobe_n(we_n), .byte_lane_mask_n(m),
		.step_or_fetch_n(st), .clk_qualify_n(q), .out_drive_en_n(oe), .sleep_request(zz), .burst_order(ord),
		.data_io_in(w.data), .data_io_out(dout), .data_io_oe_n(doe), .parity_io_in(w.parity),
		.parity_io_out(pout), .parity_io_oe_n(poe));
	sram_ctrl_model ctl (.core_clk(clk), .drive(drv), .wdata(wd), .dev_out({dout, pout}),
		.dev_oe_n({doe, poe}), .wire_val(w));

	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end

	task chk(input string n, input logic [35:0] e, input logic [35:0] s);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// One command per edge; the bench pipe mirrors the two-stage data timing
	task beat(input logic s, l, wr, o, input logic [2:0] c, input logic [5:0] ad, input logic [3:0] mk);
		@(negedge clk);
		if (!pdn) begin
			pdn = 1;
			chk("oe_n", (pk[1] == 2'h1 && !oe) ? 36'h0 : 36'hFFFFFFFFF, {doe, poe});
			if (pk[1] == 2'h1 && !oe) chk("data", mem[pa[1]], {dout, pout});
			drv = pk[1] == 2'h2;
			wd = pd[1];
			for (int i = 0; i < 4; i++) begin
				if (pk[1] == 2'h2 && !pm[1][i]) begin
					mem[pa[1]][4+8*i +: 8] = pd[1][4+8*i +: 8];
					mem[pa[1]][i] = pd[1][i];
				end
			end
		end
		{q, cs, we_n, st, a, m, oe} = {s, c, !wr, !l, ad, mk, o};
		if (!s) begin
			if (l) begin
				{live, base, k, bwr} = {c == 3'b010, ad, 2'h0, wr};
			end else begin
				k = k + 2'h1;
			end
			pk[1] = pk[0];
			pa[1] = pa[0];
			pm[1] = pm[0];
			pd[1] = pd[0];
			pk[0] = !live ? 2'h0 : bwr ? 2'h2 : 2'h1;
			pa[0] = {base[5:2], ord ? base[1:0] ^ k : base[1:0] + k};
			pm[0] = mk;
			pd[0] = {$urandom, 4'($urandom)};
			pdn = 0;
		end
	endtask

	task rnd(input int n);
		for (int i = 0; i < n; i++) begin
			beat($urandom % 8 == 0, 1'($urandom), 1'($urandom), $urandom % 4 == 0,
				$urandom % 6 == 0 ? 3'($urandom) : 3'b010, 6'($urandom), $urandom % 5 == 0 ? 4'hF : 4'($urandom));
		end
	endtask

	task rst_seq;
		@(negedge clk);
		{rst, q, st, cs} = {1'b1, 1'b0, 1'b0, 3'b101};
		repeat (20) @(negedge clk);
		{rst, pdn, live, drv} = 4'h0;
		pk = '{2'h0, 2'h0};
		repeat (4) @(negedge clk);
	endtask

	initial begin
		{q, st, we_n, oe, zz, ord, drv, cs, a, m, wd} = '0;
		// Reset from time zero so the checker never sees a false fall of reset
		rst = 1'b1;
		{err_total, check_count} = '0;
		void'($urandom(28));
		rst_seq();
		for (int i = 0; i < 64; i++) beat(0, i % 4 == 0, 1, 0, 3'b010, 6'(i & 60), 4'h0);
		rnd(300);
		$display("test linear done");
		repeat (3) beat(0, 1, 0, 0, 3'b101, 6'h00, 4'hF);
		zz = 1;
		repeat (12) beat(0, 1, 0, 0, 3'b101, 6'h00, 4'hF);
		zz = 0;
		// Wake-up adds the pin synchroniser's lag to the two-cycle exit
		repeat (8) beat(0, 1, 0, 0, 3'b101, 6'h00, 4'hF);
		rnd(150);
		$display("test sleep done");
		// Let pending writes land before reset drops the pipeline
		repeat (3) beat(0, 1, 0, 0, 3'b101, 6'h00, 4'hF);
		ord = 1;
		rst_seq();
		rnd(300);
		$display("test interleaved done");
		final_report();
	end

	initial begin
		#(40 * 5000);
		err_total++;
		final_report();
	end
endmodule

`default_nettype wire
